// ---- tb_time_tag_buffer_overflow.sv ----
// Purpose: self-checking bench of the time-tag block
// Assumes: host model issues every command
// Notes:   stamp held steady across each event
`timescale 1ns/10ps
module tb_time_tag_buffer_overflow;
  typedef struct {
    logic [3:0]  op;
    logic [1:0]  ch;
    logic [8:0]  idx;
    logic        e;
    logic [95:0] d;
  } row_type;
  logic        mclk, rstn, powerup_done_pin, ref_lock_pin, sys_preset;
  logic        nv_policy_in, cmd_valid, cmd_policy, rsp_valid, rsp_error;
  logic        policy_out, recording, err, ok;
  logic [2:0]  event_pin;
  logic [3:0]  cmd_op;
  logic [1:0]  tag_channel_select;
  logic [8:0]  entry_index;
  logic [63:0] stamp_time;
  logic [95:0] rsp_data, data;
  int          n_mismatch, num_checks, k;
  row_type     rows [12];
  time_tag_buffer_overflow i_dut (.mclk, .rstn, .event_pin, .powerup_done_pin,
    .ref_lock_pin, .stamp_time, .sys_preset, .nv_policy_in, .cmd_valid,
    .cmd_op, .tag_channel_select, .entry_index, .cmd_policy, .rsp_valid,
    .rsp_error, .rsp_data, .policy_out, .recording);
  tt_host_model i_host (.mclk, .rsp_valid, .rsp_error, .rsp_data, .cmd_valid,
    .cmd_op, .tag_channel_select, .entry_index, .cmd_policy);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================
  // Helpers
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic ask(input logic [3:0] op, input logic [1:0] ch,
    input logic [8:0] idx, input logic p, input logic e,
    input logic [95:0] d);
    i_host.issue(op, ch, idx, p, err, data, ok);
    check({94'h0, ok, err}, {94'h0, 1'b1, e});
    if (e == 1'b0) check(data, d);
  endtask : ask
  // Pin high two cycles, low three: meets the sync spacing
  task automatic pulse(input logic [2:0] m, input logic [63:0] t);
    @(negedge mclk);
    stamp_time = t;
    event_pin = m;
    repeat (2) @(negedge mclk);
    event_pin = 3'h0;
    repeat (3) @(negedge mclk);
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Sequence
  initial begin
    rstn = 1'b0;
    event_pin = 3'h0;
    powerup_done_pin = 1'b0;
    ref_lock_pin = 1'b0;
    stamp_time = 64'h0;
    sys_preset = 1'b0;
    nv_policy_in = 1'b0;
    rows[0] = '{4'h3, 2'h1, 9'h001, 1'b0, 96'ha1};
    rows[1] = '{4'h3, 2'h1, 9'h003, 1'b0, 96'ha3};
    rows[2] = '{4'h3, 2'h1, 9'h004, 1'b1, 96'h0};
    rows[3] = '{4'h3, 2'h2, 9'h001, 1'b0, 96'ha1};
    rows[4] = '{4'h3, 2'h1, 9'h000, 1'b1, 96'h0};
    rows[5] = '{4'h3, 2'h0, 9'h001, 1'b1, 96'h0};
    rows[6] = '{4'h4, 2'h0, 9'h0, 1'b0, {32'h3, 32'h1, 32'h0}};
    rows[7] = '{4'h5, 2'h1, 9'h0, 1'b0, 96'h3};
    rows[8] = '{4'h6, 2'h0, 9'h0, 1'b0, 96'h0};
    rows[9] = '{4'h9, 2'h0, 9'h0, 1'b0, 96'h0};
    rows[10] = '{4'h3, 2'h1, 9'h001, 1'b0, 96'ha1};
    rows[11] = '{4'hf, 2'h1, 9'h001, 1'b1, 96'h0};
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    pulse(3'h4, 64'hff);
    check({95'h0, recording}, 96'h0);
    powerup_done_pin = 1'b1;
    ref_lock_pin = 1'b1;
    repeat (6) @(negedge mclk);
    check({95'h0, recording}, 96'h1);
    pulse(3'h3, 64'ha1);
    pulse(3'h1, 64'ha2);
    pulse(3'h1, 64'ha3);
    for (k = 0; k < 12; k++) begin
      ask(rows[k].op, rows[k].ch, rows[k].idx, 1'b0, rows[k].e, rows[k].d);
    end
    $display("test table done");
    for (k = 1; k <= 258; k++) pulse(3'h4, 64'(k));
    ask(4'h3, 2'h3, 9'h100, 1'b0, 1'b0, 96'h100);
    ask(4'h7, 2'h3, 9'h0, 1'b0, 1'b0, 96'h2);
    ask(4'h6, 2'h0, 9'h0, 1'b0, 1'b0, 96'h2);
    ask(4'h5, 2'h3, 9'h0, 1'b0, 1'b0, 96'h100);
    $display("test keep first done");
    ask(4'h8, 2'h0, 9'h0, 1'b1, 1'b0, 96'h0);
    ask(4'h9, 2'h0, 9'h0, 1'b0, 1'b0, 96'h1);
    for (k = 259; k <= 261; k++) pulse(3'h4, 64'(k));
    ask(4'h3, 2'h3, 9'h001, 1'b0, 1'b0, 96'h4);
    ask(4'h3, 2'h3, 9'h100, 1'b0, 1'b0, 96'h105);
    ask(4'h7, 2'h3, 9'h0, 1'b0, 1'b0, 96'h5);
    $display("test keep last done");
    ask(4'h1, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    ask(4'h6, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    ask(4'h4, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    $display("test clear done");
    for (k = 1; k <= 258; k++) pulse(3'h2, 64'(k));
    fork
      i_host.issue(4'h6, 2'h0, 9'h0, 1'b0, err, data, ok);
      begin
        @(negedge mclk);
        sys_preset = 1'b1;
        @(negedge mclk);
        sys_preset = 1'b0;
      end
    join
    check({95'h0, ok}, 96'h0);
    ask(4'h6, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    ask(4'h4, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    ask(4'h9, 2'h0, 9'h0, 1'b0, 1'b0, 96'h0);
    $display("test preset done");
    @(negedge mclk);
    rstn = 1'b0;
    nv_policy_in = 1'b1;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    ask(4'h9, 2'h0, 9'h0, 1'b0, 1'b0, 96'h1);
    check({95'h0, policy_out}, 96'h1);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_time_tag_buffer_overflow

// ---- time_tag_buffer_overflow.sv ----
// Purpose: three-channel event time-stamp store and host query engine
// Assumes: stamp_time on mclk; pins async; nv_policy_in from a NV store
// Notes:   one command per cycle at most; answer one cycle later
`timescale 1ns/10ps
module time_tag_buffer_overflow (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic [tt_pkg::NUM_CH-1:0]     event_pin,
  input  wire logic                          powerup_done_pin,
  input  wire logic                          ref_lock_pin,
  input  wire logic [tt_pkg::STAMP_W-1:0]    stamp_time,
  input  wire logic                          sys_preset,
  input  wire logic                          nv_policy_in,
  input  wire logic                          cmd_valid,
  input  wire logic [3:0]                    cmd_op,
  input  wire logic [tt_pkg::CH_W-1:0]       tag_channel_select,
  input  wire logic [tt_pkg::IDX_W-1:0]      entry_index,
  input  wire logic                          cmd_policy,
  output logic                               rsp_valid,
  output logic                               rsp_error,
  output logic      [tt_pkg::RSP_W-1:0]      rsp_data,
  output logic                               policy_out,
  output logic                               recording
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                         loaded;
    logic                         armed;
    logic                         busy;
    tt_pkg::policy_type           policy;
    logic                         rsp_valid;
    logic                         rsp_error;
    logic [tt_pkg::RSP_W-1:0]     rsp_data;
    logic                         recording;
  } top_state_type;

  top_state_type q;
  top_state_type d;

  logic [tt_pkg::SYNC_N-1:0] pin_raw;
  logic [tt_pkg::SYNC_N-1:0] pin_level;
  logic [tt_pkg::SYNC_N-1:0] pin_rise;

  logic [tt_pkg::NUM_CH-1:0]                   rec_v;
  logic [tt_pkg::NUM_CH-1:0]                   clr_buf_v;
  logic [tt_pkg::NUM_CH-1:0]                   clr_ovf_v;
  logic [tt_pkg::NUM_CH-1:0][tt_pkg::STAMP_W-1:0] rd_data_v;
  logic [tt_pkg::NUM_CH-1:0][tt_pkg::CNT_W-1:0]   count_v;
  logic [tt_pkg::NUM_CH-1:0][tt_pkg::OVF_W-1:0]   ovf_v;

  logic                       ch_ok;
  logic [tt_pkg::CH_W-1:0]    ch_sel;
  logic                       accept;
  logic                       can_record;
  tt_pkg::cmd_type            op;

  // ==========================================================
  // Pin synchronisers
  assign pin_raw = {ref_lock_pin, powerup_done_pin, event_pin};

  tt_pin_sync u_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (pin_raw),
    .level (pin_level),
    .rise  (pin_rise)
  );

  // ==========================================================
  // Command decode
  assign op     = tt_pkg::cmd_type'(cmd_op);
  assign ch_ok  = tag_channel_select >= tt_pkg::CH_FIRST &&
                  tag_channel_select <= tt_pkg::CH_LAST;
  assign ch_sel = ch_ok ? tag_channel_select - 2'h1 : '0;

  // Preset takes the cycle; a command in the same cycle is dropped
  assign accept = cmd_valid & ~sys_preset;

  // Events that land during host access are lost, not queued
  assign can_record = q.armed & ~q.busy & ~cmd_valid
                      & ~sys_preset;

  // ==========================================================
  // Channel stores
  genvar c;
  generate
    for (c = 0; c < tt_pkg::NUM_CH; c++) begin : g_ch
      tt_chan_if chan_bus ();

      assign rec_v[c] = can_record & pin_rise[c];
      assign clr_buf_v[c] = sys_preset
                          | (accept & op == tt_pkg::OP_CLEAR_ALL)
                          | (accept & op == tt_pkg::OP_CLEAR_ONE
                             & ch_ok & ch_sel == c);
      assign clr_ovf_v[c] = sys_preset
                          | (accept & op == tt_pkg::OP_CLEAR_ALL);

      assign chan_bus.rec       = rec_v[c];
      assign chan_bus.stamp     = stamp_time;
      assign chan_bus.clear_buf = clr_buf_v[c];
      assign chan_bus.clear_ovf = clr_ovf_v[c];
      assign chan_bus.policy    = q.policy;
      assign chan_bus.rd_idx    = entry_index;
      assign rd_data_v[c]       = chan_bus.rd_data;
      assign count_v[c]         = chan_bus.count;
      assign ovf_v[c]           = chan_bus.ovf;

      tt_chan_store u_store (
        .mclk (mclk),
        .rstn (rstn),
        .bus  (chan_bus.store)
      );
    end
  endgenerate

  // ==========================================================
  // Control and answers
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.rsp_error = 1'b0;
    d.busy      = 1'b0;
    d.recording = can_record;

    // Policy is copied from the NV store once, after reset release
    if (!q.loaded) begin
      d.loaded = 1'b1;
      d.policy = tt_pkg::policy_type'(nv_policy_in);
    end

    // Armed stays set: later loss of lock does not stop recording
    if (q.loaded && pin_level[tt_pkg::SYNC_PWR]
        && pin_level[tt_pkg::SYNC_LOCK]) begin
      d.armed = 1'b1;
    end

    if (sys_preset) begin
      d.policy = tt_pkg::PRESET_POLICY;
    end else if (accept) begin
      d.busy      = 1'b1;
      d.rsp_valid = 1'b1;
      d.rsp_data  = '0;
      unique case (op)
        tt_pkg::OP_CLEAR_ALL: begin
          d.rsp_data = '0;
        end
        tt_pkg::OP_CLEAR_ONE: begin
          d.rsp_error = ~ch_ok;
        end
        tt_pkg::OP_READ_ENTRY: begin
          if (!ch_ok || entry_index < tt_pkg::IDX_FIRST
              || entry_index > count_v[ch_sel]) begin
            d.rsp_error = 1'b1;
          end else begin
            d.rsp_data = {32'h0000_0000, rd_data_v[ch_sel]};
          end
        end
        tt_pkg::OP_POINTS_ALL: begin
          d.rsp_data = {23'h000000, count_v[0],
                        23'h000000, count_v[1],
                        23'h000000, count_v[2]};
        end
        tt_pkg::OP_POINTS_ONE: begin
          d.rsp_error = ~ch_ok;
          d.rsp_data  = {87'h0, count_v[ch_sel]};
        end
        tt_pkg::OP_OVF_ALL: begin
          d.rsp_data = {ovf_v[0], ovf_v[1], ovf_v[2]};
        end
        tt_pkg::OP_OVF_ONE: begin
          d.rsp_error = ~ch_ok;
          d.rsp_data  = {64'h0, ovf_v[ch_sel]};
        end
        tt_pkg::OP_SET_POLICY: begin
          d.policy = tt_pkg::policy_type'(cmd_policy);
        end
        tt_pkg::OP_GET_POLICY: begin
          d.rsp_data = {95'h0, q.policy};
        end
        default: begin
          d.rsp_error = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign rsp_valid  = q.rsp_valid;
  assign rsp_error  = q.rsp_error;
  assign rsp_data   = q.rsp_data;
  assign policy_out = q.policy;
  assign recording  = q.recording;

endmodule : time_tag_buffer_overflow

// ---- tt_chan_if.sv ----
// Purpose: carrier between the top and one channel store
// Assumes: all signals on mclk
// Notes:   store outputs are combinational from its state and rd_idx
`timescale 1ns/10ps
interface tt_chan_if;
  logic                        rec;
  logic [tt_pkg::STAMP_W-1:0]  stamp;
  logic                        clear_buf;
  logic                        clear_ovf;
  tt_pkg::policy_type          policy;
  logic [tt_pkg::IDX_W-1:0]    rd_idx;
  logic [tt_pkg::STAMP_W-1:0]  rd_data;
  logic [tt_pkg::CNT_W-1:0]    count;
  logic [tt_pkg::OVF_W-1:0]    ovf;

  modport ctrl  (output rec, stamp, clear_buf, clear_ovf, policy, rd_idx,
                 input  rd_data, count, ovf);
  modport store (input  rec, stamp, clear_buf, clear_ovf, policy, rd_idx,
                 output rd_data, count, ovf);
endinterface : tt_chan_if

// ---- tt_chan_store.sv ----
// Purpose: one channel's 256-entry stamp store with overflow count
// Assumes: caller never records and clears in the same cycle
// Notes:   entry 1 is always the oldest retained stamp
`timescale 1ns/10ps
module tt_chan_store (
  input wire logic mclk,
  input wire logic rstn,
  tt_chan_if.store bus
);
  typedef struct packed {
    logic [tt_pkg::DEPTH-1:0][tt_pkg::STAMP_W-1:0] mem;
    logic [tt_pkg::PTR_W-1:0]                      wr_ptr;
    logic [tt_pkg::CNT_W-1:0]                      count;
    logic [tt_pkg::OVF_W-1:0]                      ovf;
  } store_state_type;

  store_state_type          q;
  store_state_type          d;
  logic [tt_pkg::PTR_W-1:0] oldest;
  logic [tt_pkg::PTR_W-1:0] phys;

  always_comb begin
    d = q;
    if (bus.clear_buf) begin
      d.wr_ptr = '0;
      d.count  = '0;
    end else if (bus.rec) begin
      if (q.count != tt_pkg::FULL_COUNT) begin
        d.mem[q.wr_ptr] = bus.stamp;
        d.wr_ptr        = q.wr_ptr + 8'h01;
        d.count         = q.count + 9'h001;
      end else if (bus.policy == tt_pkg::KEEP_LAST) begin
        d.mem[q.wr_ptr] = bus.stamp;
        d.wr_ptr        = q.wr_ptr + 8'h01;
      end
      if (q.count == tt_pkg::FULL_COUNT && q.ovf != tt_pkg::OVF_MAX) begin
        d.ovf = q.ovf + 32'h0000_0001;
      end
    end
    if (bus.clear_ovf) begin
      d.ovf = '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Read side: pure lookup, state untouched
  assign oldest      = (q.count == tt_pkg::FULL_COUNT) ? q.wr_ptr : '0;
  assign phys        = oldest + bus.rd_idx[tt_pkg::PTR_W-1:0] - 8'h01;
  assign bus.rd_data = q.mem[phys];
  assign bus.count   = q.count;
  assign bus.ovf     = q.ovf;
endmodule : tt_chan_store

// ---- tt_chk_asserts.sv ----
// Purpose: port checks of the time-tag block
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module
`timescale 1ns/10ps
module tt_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        powerup_done_pin,
  input wire logic        ref_lock_pin,
  input wire logic        sys_preset,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_op,
  input wire logic [1:0]  tag_channel_select,
  input wire logic [8:0]  entry_index,
  input wire logic        cmd_policy,
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic [95:0] rsp_data,
  input wire logic        policy_out,
  input wire logic        recording
);
  // ==========================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic take, seen_q;
  assign take = cmd_valid && !sys_preset;
  // First recording marks the end of the arming wait
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) seen_q <= 1'b0;
    else if (recording) seen_q <= 1'b1;
  end
  cmd_answer_a: assert property (take |=> rsp_valid)
    else $error("command not answered");
  idle_quiet_a: assert property (!take |=> !rsp_valid)
    else $error("answer without command");
  bad_chan_a: assert property (take && cmd_op inside {4'h3, 4'h5, 4'h7}
    && tag_channel_select == 2'h0 |=> rsp_error) else $error("bad channel");
  bad_index_a: assert property (take && cmd_op == 4'h3
    && (entry_index == 9'h0 || entry_index > 9'h100) |=> rsp_error)
    else $error("bad index accepted");
  arm_first_a: assert property (recording && !seen_q |->
    $past(powerup_done_pin, 2) && $past(ref_lock_pin, 2))
    else $error("recording before arming");
  access_block_a: assert property (cmd_valid |=> !recording)
    else $error("recording during access");
  preset_first_a: assert property (sys_preset |=> !policy_out)
    else $error("preset kept policy");
  set_policy_a: assert property (take && cmd_op == 4'h8 |=>
    policy_out == $past(cmd_policy)) else $error("policy not set");
  policy_read_a: assert property (rsp_valid && $past(cmd_op) == 4'h9
    |-> rsp_data == {95'h0, policy_out}) else $error("policy readback");
  count_range_a: assert property (rsp_valid && $past(cmd_op) == 4'h5
    && !rsp_error |-> rsp_data <= 96'h100) else $error("count range");
  preset_ovf_a: assert property (sys_preset ##[1:8] (take
    && cmd_op == 4'h6) |=> rsp_data == 96'h0) else $error("ovf kept");
  cover property (take && cmd_op == 4'h3 ##1 !rsp_error);
  cover property (sys_preset && cmd_valid);
  cover property (recording && !seen_q);
endmodule : tt_chk

bind time_tag_buffer_overflow tt_chk i_chk (.mclk, .rstn, .powerup_done_pin,
  .ref_lock_pin, .sys_preset, .cmd_valid, .cmd_op, .tag_channel_select,
  .entry_index, .cmd_policy, .rsp_valid, .rsp_error, .rsp_data, .policy_out,
  .recording);

// ---- tt_host_model.sv ----
// Purpose: host command interpreter model
// Assumes: commands taken on the rising edge of mclk
// Notes:   idle channel and index inverted so stale values never pass
`timescale 1ns/10ps
module tt_host_model (
  input  wire logic        mclk,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [95:0] rsp_data,
  output logic             cmd_valid,
  output logic      [3:0]  cmd_op,
  output logic      [1:0]  tag_channel_select,
  output logic      [8:0]  entry_index,
  output logic             cmd_policy
);
  // ==========================================
  // Command issue
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    tag_channel_select = 2'h0;
    entry_index = 9'h0;
    cmd_policy = 1'b0;
  end
  task automatic issue(input logic [3:0] op, input logic [1:0] ch,
    input logic [8:0] idx, input logic pol, output logic err,
    output logic [95:0] d, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    d = 96'h0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    tag_channel_select = ch;
    entry_index = idx;
    cmd_policy = pol;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    tag_channel_select = ~ch;
    entry_index = ~idx;
    // Answer stands one cycle only: look at each falling edge
    for (n = 0; n < 4 && !ok; n++) begin
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        err = rsp_error;
        d = rsp_data;
      end else begin
        @(negedge mclk);
      end
    end
  endtask : issue
endmodule : tt_host_model

// ---- tt_pin_sync.sv ----
// Purpose: two-stage synchronisers with rising-edge pulses
// Assumes: inputs are asynchronous pins
// Notes:   edge detect looks only at the second and third stages
`timescale 1ns/10ps
module tt_pin_sync (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [tt_pkg::SYNC_N-1:0] pin,
  output logic      [tt_pkg::SYNC_N-1:0] level,
  output logic      [tt_pkg::SYNC_N-1:0] rise
);
  typedef struct packed {
    logic [tt_pkg::SYNC_N-1:0] meta;
    logic [tt_pkg::SYNC_N-1:0] sync;
    logic [tt_pkg::SYNC_N-1:0] last;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  always_comb begin
    d      = q;
    d.meta = pin;
    d.sync = q.meta;
    d.last = q.sync;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Per-bit outputs
  genvar i;
  generate
    for (i = 0; i < tt_pkg::SYNC_N; i++) begin : g_bit
      assign level[i] = q.sync[i];
      assign rise[i]  = q.sync[i] & ~q.last[i];
    end
  endgenerate
endmodule : tt_pin_sync

// ---- tt_pkg.sv ----
// Purpose: shared constants and types of the time-tag buffer block
// Assumes: three channels, 256 entries each, one clock
// Notes:   every width, count, code and preset value lives here; reset loads zero in each module
package tt_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH  = 3;
  localparam int CH_W    = 2;
  localparam int DEPTH   = 256;
  localparam int PTR_W   = 8;
  localparam int CNT_W   = 9;
  localparam int IDX_W   = 9;
  localparam int STAMP_W = 64;
  localparam int OVF_W   = 32;
  localparam int RSP_W   = 96;
  localparam int SYNC_N  = 5;
  localparam int SYNC_PWR  = 3;
  localparam int SYNC_LOCK = 4;

  // ==========================================================
  // Values
  localparam logic [CNT_W-1:0] FULL_COUNT = 9'h100;
  localparam logic [OVF_W-1:0] OVF_MAX    = 32'hffff_ffff;
  localparam logic [IDX_W-1:0] IDX_FIRST  = 9'h001;
  localparam logic [CH_W-1:0]  CH_FIRST   = 2'h1;
  localparam logic [CH_W-1:0]  CH_LAST    = 2'h3;

  // ==========================================================
  // Host commands
  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_CLEAR_ALL  = 4'h1,
    OP_CLEAR_ONE  = 4'h2,
    OP_READ_ENTRY = 4'h3,
    OP_POINTS_ALL = 4'h4,
    OP_POINTS_ONE = 4'h5,
    OP_OVF_ALL    = 4'h6,
    OP_OVF_ONE    = 4'h7,
    OP_SET_POLICY = 4'h8,
    OP_GET_POLICY = 4'h9
  } cmd_type;

  typedef enum logic {
    KEEP_FIRST = 1'b0,
    KEEP_LAST  = 1'b1
  } policy_type;

  localparam policy_type PRESET_POLICY = KEEP_FIRST;

endpackage : tt_pkg
